/* File: rtl/ffpcd_pkg.sv */
// Purpose: constants and types for the fast program command sequencer (host side)
// Assumes: x16 parallel NOR flash, 23 address bits, one 10 MHz clock
// Notes:   all command codes are the flash's hexadecimal bus-write values
//
// How it works
// - bypass exit writes 90 then 00
// - enter 555/AA 2AA/55 555/20, abort ends 555/F0
// - bypass program writes A0 then address/data
// - bypass block erase 80 then 30 per block
// - bypass chip erase writes 80 then 10
// - bypass cfi is one 98 write
// - buffer program 25, count, words; unlock skipped in bypass
// - host loads N further words after first
// - buffered words share A22-A5, A4-A0 select word
// - confirm 29 at the setup block address
// - whole buffer sequence stays within 36 writes in bypass; a full page outside bypass takes 37 with the unlock
// - enhanced program unlock outside bypass, 33, 256 words, confirm

package ffpcd_pkg;

	// ----------------------------------------------------------------
	// bus shape
	// ----------------------------------------------------------------
	localparam int ADDR_W      = 23;
	localparam int DATA_W      = 16;
	localparam int PAGE_LSB    = 5;    // a22..a5 select the buffer page
	localparam int ENH_LSB     = 8;    // enhanced buffer spans 256 words
	localparam int BUF_WORDS   = 32;
	localparam int ENH_WORDS   = 256;
	localparam int MAX_CYCLES  = 36;
	localparam int WBUF_FIXED  = 5;    // writes beyond the n loads

	// ----------------------------------------------------------------
	// addresses and command codes
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h0002aa;
	localparam logic [DATA_W-1:0] D_UNL1    = 16'h00aa;
	localparam logic [DATA_W-1:0] D_UNL2    = 16'h0055;
	localparam logic [DATA_W-1:0] D_BYP_ON  = 16'h0020;
	localparam logic [DATA_W-1:0] D_ABORT   = 16'h00f0;
	localparam logic [DATA_W-1:0] D_PROG    = 16'h00a0;
	localparam logic [DATA_W-1:0] D_ERASE   = 16'h0080;
	localparam logic [DATA_W-1:0] D_BLK     = 16'h0030;
	localparam logic [DATA_W-1:0] D_CHIP    = 16'h0010;
	localparam logic [DATA_W-1:0] D_CFI     = 16'h0098;
	localparam logic [DATA_W-1:0] D_EXIT1   = 16'h0090;
	localparam logic [DATA_W-1:0] D_EXIT2   = 16'h0000;
	localparam logic [DATA_W-1:0] D_WBUF    = 16'h0025;
	localparam logic [DATA_W-1:0] D_CONFIRM = 16'h0029;
	localparam logic [DATA_W-1:0] D_ENH     = 16'h0033;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS   = 100;
	localparam int T_WP_NS  = 40;      // write enable low, least
	localparam int T_WPH_NS = 30;      // write enable high, least
	localparam int T_BUSY_NS = 500;    // ready/busy settles after a start
	localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// host operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_BYP_ENTER  = 4'h0,
		OP_BYP_EXIT   = 4'h1,
		OP_PROGRAM    = 4'h2,
		OP_BLK_ERASE  = 4'h3,
		OP_CHIP_ERASE = 4'h4,
		OP_CFI        = 4'h5,
		OP_WBUF       = 4'h6,
		OP_ENH        = 4'h7,
		OP_ABORT      = 4'h8
	} ffpcd_op_t;

endpackage

/* File: rtl/ffpcd_top.sv */
// Purpose: host sequencer issuing unlock bypass and buffered program commands to a nor flash
// Assumes: command, word stream and flash ready/busy come from outside; ready/busy is asynchronous
// Notes:   write only; array reads, status polling and extended block commands are not driven
`timescale 1ns/10ps
`default_nettype none

module ffpcd_top #(
	parameter int BUF_WORDS = ffpcd_pkg::BUF_WORDS
) (
	// clock and reset
	input  wire logic                          REF_CLK,
	input  wire logic                          SYS_RST,
	// command request
	input  wire logic                          CMD_VALID,
	input  wire logic [3:0]                    CMD_OP,
	input  wire logic [ffpcd_pkg::ADDR_W-1:0]  CMD_ADDR,
	input  wire logic [ffpcd_pkg::DATA_W-1:0]  CMD_DATA,
	input  wire logic [7:0]                    CMD_COUNT,
	// command answer
	output logic                               CMD_ACCEPT,
	output logic                               CMD_REFUSED,
	output logic                               CMD_DONE,
	output logic                               BUSY,
	output logic                               BYPASS,
	// word stream for buffer loads and extra erase blocks
	input  wire logic                          WD_VALID,
	input  wire logic [ffpcd_pkg::ADDR_W-1:0]  WD_ADDR,
	input  wire logic [ffpcd_pkg::DATA_W-1:0]  WD_DATA,
	output logic                               WD_READY,
	// flash pins
	output logic [ffpcd_pkg::ADDR_W-1:0]       FL_ADDR,
	output logic [ffpcd_pkg::DATA_W-1:0]       FL_DQ_O,
	output logic                               FL_DQ_OE,
	output logic                               FL_CE_N,
	output logic                               FL_WE_N,
	output logic                               FL_OE_N,
	input  wire logic                          FL_RB_N
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// buffer size keeps the sequence within its write budget
	if (BUF_WORDS < 1 || BUF_WORDS + ffpcd_pkg::WBUF_FIXED - 1 > ffpcd_pkg::MAX_CYCLES) begin : g_bad_buf
		$error("buffer size exceeds write budget");
	end

	typedef enum logic [8:0] {
		S_IDLE   = 9'b000000001,
		S_UNL1   = 9'b000000010,
		S_UNL2   = 9'b000000100,
		S_CODE   = 9'b000001000,
		S_ARG    = 9'b000010000,
		S_LOAD   = 9'b000100000,
		S_CONF   = 9'b001000000,
		S_SETTLE = 9'b010000000,
		S_WAIT   = 9'b100000000
	} ffpcd_st_t;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic starts_op(input ffpcd_pkg::ffpcd_op_t op);
		return op inside {ffpcd_pkg::OP_PROGRAM, ffpcd_pkg::OP_BLK_ERASE, ffpcd_pkg::OP_CHIP_ERASE,
			ffpcd_pkg::OP_WBUF, ffpcd_pkg::OP_ENH};
	endfunction

	function automatic logic is_buffered(input ffpcd_pkg::ffpcd_op_t op);
		return op inside {ffpcd_pkg::OP_WBUF, ffpcd_pkg::OP_ENH};
	endfunction

	ffpcd_wr_if wif ();

	ffpcd_st_t                    st_q, st_d;
	ffpcd_pkg::ffpcd_op_t         op_q;
	logic [ffpcd_pkg::ADDR_W-1:0] addr_q, wd_a_q;
	logic [ffpcd_pkg::DATA_W-1:0] data_q, wd_d_q;
	logic [7:0]                   n_q;
	logic [8:0]                   cnt_q, cnt_d;
	logic [7:0]                   idx_q;
	logic [3:0]                   tmr_q;
	logic                         req_q, bypass_q, bypass_d;
	logic                         acc_q, ref_q, done_q, busy_q, rdy_q, oe_n_q;
	logic                         rb1_q, rb2_q, rb3_q, rb_ok_q;

	// ----------------------------------------------------------------
	// command acceptance
	// ----------------------------------------------------------------
	wire ffpcd_pkg::ffpcd_op_t cmd_op = ffpcd_pkg::ffpcd_op_t'(CMD_OP);
	wire cmd_known   = (CMD_OP <= 4'h8);
	wire need_byp    = cmd_op inside {ffpcd_pkg::OP_BYP_EXIT, ffpcd_pkg::OP_PROGRAM,
		ffpcd_pkg::OP_BLK_ERASE, ffpcd_pkg::OP_CHIP_ERASE, ffpcd_pkg::OP_CFI};
	// a count beyond the buffer would break the 36-write limit
	wire cnt_bad     = (cmd_op == ffpcd_pkg::OP_WBUF) && ({1'b0, CMD_COUNT} >= 9'(BUF_WORDS));
	wire cmd_bad     = !cmd_known || cnt_bad || (need_byp && !bypass_q)
		|| (cmd_op == ffpcd_pkg::OP_BYP_ENTER && bypass_q);
	wire cmd_take    = (st_q == S_IDLE) && CMD_VALID && !acc_q && !ref_q;
	// entry and abort always unlock; buffered ops unlock only outside bypass
	wire cmd_unlock  = cmd_op inside {ffpcd_pkg::OP_BYP_ENTER, ffpcd_pkg::OP_ABORT}
		|| (is_buffered(cmd_op) && !bypass_q);
	wire [8:0] cnt_init = (cmd_op == ffpcd_pkg::OP_WBUF) ? {1'b0, CMD_COUNT} + 9'h001 :
		(cmd_op == ffpcd_pkg::OP_ENH) ? 9'(ffpcd_pkg::ENH_WORDS) : {1'b0, CMD_COUNT};

	// ----------------------------------------------------------------
	// address and data of the write in hand
	// ----------------------------------------------------------------
	wire op_unl_code = op_q inside {ffpcd_pkg::OP_BYP_ENTER, ffpcd_pkg::OP_ABORT};
	wire has_arg     = op_q inside {ffpcd_pkg::OP_BYP_EXIT, ffpcd_pkg::OP_PROGRAM,
		ffpcd_pkg::OP_BLK_ERASE, ffpcd_pkg::OP_CHIP_ERASE, ffpcd_pkg::OP_WBUF};
	// page bits forced from the setup address, low bits pick the word
	wire [ffpcd_pkg::ADDR_W-1:0] page_addr = {addr_q[ffpcd_pkg::ADDR_W-1:ffpcd_pkg::PAGE_LSB],
		wd_a_q[ffpcd_pkg::PAGE_LSB-1:0]};
	// enhanced loads walk the 256 word locations in order
	wire [ffpcd_pkg::ADDR_W-1:0] enh_addr  = {addr_q[ffpcd_pkg::ADDR_W-1:ffpcd_pkg::ENH_LSB], idx_q};
	wire [ffpcd_pkg::ADDR_W-1:0] enh_base  = {addr_q[ffpcd_pkg::ADDR_W-1:ffpcd_pkg::ENH_LSB], 8'h00};
	wire [ffpcd_pkg::ADDR_W-1:0] load_addr = (op_q == ffpcd_pkg::OP_WBUF) ? page_addr :
		(op_q == ffpcd_pkg::OP_ENH) ? enh_addr : wd_a_q;
	wire [ffpcd_pkg::DATA_W-1:0] load_data = (op_q == ffpcd_pkg::OP_BLK_ERASE) ? ffpcd_pkg::D_BLK : wd_d_q;
	wire [ffpcd_pkg::DATA_W-1:0] code_data =
		(op_q == ffpcd_pkg::OP_BYP_ENTER) ? ffpcd_pkg::D_BYP_ON :
		(op_q == ffpcd_pkg::OP_ABORT)     ? ffpcd_pkg::D_ABORT :
		(op_q == ffpcd_pkg::OP_BYP_EXIT)  ? ffpcd_pkg::D_EXIT1 :
		(op_q == ffpcd_pkg::OP_PROGRAM)   ? ffpcd_pkg::D_PROG :
		(op_q == ffpcd_pkg::OP_CFI)       ? ffpcd_pkg::D_CFI :
		(op_q == ffpcd_pkg::OP_WBUF)      ? ffpcd_pkg::D_WBUF :
		(op_q == ffpcd_pkg::OP_ENH)       ? ffpcd_pkg::D_ENH : ffpcd_pkg::D_ERASE;
	wire [ffpcd_pkg::DATA_W-1:0] arg_data =
		(op_q == ffpcd_pkg::OP_PROGRAM)    ? data_q :
		(op_q == ffpcd_pkg::OP_BLK_ERASE)  ? ffpcd_pkg::D_BLK :
		(op_q == ffpcd_pkg::OP_CHIP_ERASE) ? ffpcd_pkg::D_CHIP :
		(op_q == ffpcd_pkg::OP_WBUF)       ? {8'h00, n_q} : ffpcd_pkg::D_EXIT2;
	// confirm goes back to the setup block address
	wire [ffpcd_pkg::ADDR_W-1:0] conf_addr = (op_q == ffpcd_pkg::OP_ENH) ? enh_base : addr_q;

	assign wif.addr = (st_q == S_UNL1) ? ffpcd_pkg::UNLOCK_A1 :
		(st_q == S_UNL2) ? ffpcd_pkg::UNLOCK_A2 :
		(st_q == S_CODE && op_unl_code) ? ffpcd_pkg::UNLOCK_A1 :
		(st_q == S_LOAD) ? load_addr :
		(st_q == S_CONF) ? conf_addr : addr_q;
	assign wif.data = (st_q == S_UNL1) ? ffpcd_pkg::D_UNL1 :
		(st_q == S_UNL2) ? ffpcd_pkg::D_UNL2 :
		(st_q == S_CODE) ? code_data :
		(st_q == S_ARG)  ? arg_data :
		(st_q == S_LOAD) ? load_data : ffpcd_pkg::D_CONFIRM;
	assign wif.req  = req_q;

	// ----------------------------------------------------------------
	// write issue; loads wait for a stream word
	// ----------------------------------------------------------------
	wire issuing  = st_q inside {S_UNL1, S_UNL2, S_CODE, S_ARG, S_CONF};
	// each further load waits for the next word from the stream
	wire ld_take  = (st_q == S_LOAD) && !req_q && WD_VALID && !rdy_q;
	wire issue    = (issuing && !req_q) || ld_take;
	wire req_d    = issue ? 1'b1 : (wif.done ? 1'b0 : req_q);
	wire fin_op   = starts_op(op_q);
	wire last_ld  = (cnt_q == 9'h001);

	// sequence of writes per operation
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		bypass_d = bypass_q;
		unique case (st_q)
			S_IDLE:   if (cmd_take && !cmd_bad) begin
				st_d  = cmd_unlock ? S_UNL1 : S_CODE;
				cnt_d = cnt_init;
			end
			S_UNL1:   if (wif.done) st_d = S_UNL2;
			S_UNL2:   if (wif.done) st_d = S_CODE;
			S_CODE:   if (wif.done) begin
				// entry completes on the third write
				if (op_q == ffpcd_pkg::OP_BYP_ENTER) bypass_d = 1'b1;
				st_d = has_arg ? S_ARG : (op_q == ffpcd_pkg::OP_ENH) ? S_LOAD : S_IDLE;
			end
			S_ARG:    if (wif.done) begin
				// only the second exit write leaves bypass mode
				if (op_q == ffpcd_pkg::OP_BYP_EXIT) bypass_d = 1'b0;
				// further blocks repeat the 30 write
				st_d = (op_q == ffpcd_pkg::OP_WBUF || (op_q == ffpcd_pkg::OP_BLK_ERASE && cnt_q != 9'h000))
					? S_LOAD : fin_op ? S_SETTLE : S_IDLE;
			end
			S_LOAD:   if (wif.done) begin
				cnt_d = cnt_q - 9'h001;
				if (last_ld) st_d = is_buffered(op_q) ? S_CONF : S_SETTLE;
			end
			S_CONF:   if (wif.done) st_d = S_SETTLE;
			S_SETTLE: if (tmr_q == 4'h0) st_d = S_WAIT;
			S_WAIT:   if (rb_ok_q) st_d = S_IDLE;
		endcase
	end

	// sequencer state and latched command
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q <= S_IDLE; cnt_q <= 9'h000; bypass_q <= 1'b0; req_q <= 1'b0;
			op_q <= ffpcd_pkg::OP_BYP_ENTER; addr_q <= '0; data_q <= '0; n_q <= 8'h00;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; bypass_q <= bypass_d; req_q <= req_d;
			if (cmd_take) begin
				op_q <= cmd_op; addr_q <= CMD_ADDR; data_q <= CMD_DATA; n_q <= CMD_COUNT;
			end
		end
	end

	// stream word latch and enhanced word index
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wd_a_q <= '0; wd_d_q <= '0; idx_q <= 8'h00; tmr_q <= 4'h0;
		end else begin
			if (ld_take) begin
				wd_a_q <= WD_ADDR; wd_d_q <= WD_DATA;
			end
			if (st_q == S_IDLE) idx_q <= 8'h00;
			else if (st_q == S_LOAD && wif.done) idx_q <= idx_q + 8'h01;
			tmr_q <= (st_q != S_SETTLE) ? 4'(ffpcd_pkg::BUSY_CYC) : tmr_q - 4'h1;
		end
	end

	// ready/busy sync; a level counts once second and third stage agree
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rb1_q <= 1'b1; rb2_q <= 1'b1; rb3_q <= 1'b1; rb_ok_q <= 1'b1;
		end else begin
			rb1_q <= FL_RB_N; rb2_q <= rb1_q; rb3_q <= rb2_q;
			if (rb2_q == rb3_q) rb_ok_q <= rb3_q;
		end
	end

	// answer flags, all registered
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			acc_q <= 1'b0; ref_q <= 1'b0; done_q <= 1'b0; busy_q <= 1'b0; rdy_q <= 1'b0; oe_n_q <= 1'b1;
		end else begin
			acc_q  <= cmd_take && !cmd_bad;
			ref_q  <= cmd_take && cmd_bad;
			done_q <= (st_q != S_IDLE) && (st_d == S_IDLE);
			busy_q <= (st_d != S_IDLE);
			rdy_q  <= ld_take;
			oe_n_q <= 1'b1;
		end
	end

	ffpcd_writer u_writer (
		.clk (REF_CLK),
		.rst (SYS_RST),
		.wif (wif)
	);

	assign CMD_ACCEPT  = acc_q;
	assign CMD_REFUSED = ref_q;
	assign CMD_DONE    = done_q;
	assign BUSY        = busy_q;
	assign BYPASS      = bypass_q;
	assign WD_READY    = rdy_q;
	assign FL_ADDR     = wif.pin_addr;
	assign FL_DQ_O     = wif.pin_dq;
	assign FL_DQ_OE    = wif.pin_dq_oe;
	assign FL_CE_N     = wif.pin_ce_n;
	assign FL_WE_N     = wif.pin_we_n;
	assign FL_OE_N     = oe_n_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_exit_second: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		st_q == S_ARG && op_q == ffpcd_pkg::OP_BYP_EXIT && wif.done |-> wif.data == 16'h0000 ##1 !bypass_q ##1 !BYPASS)
		else $error("bypass exit did not clear mode");
	chk_bypass_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		$fell(bypass_q) |-> $past(st_q) == S_ARG && $past(op_q) == ffpcd_pkg::OP_BYP_EXIT)
		else $error("bypass left without exit sequence");
	chk_enter_code: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		req_q && st_q == S_CODE && op_q == ffpcd_pkg::OP_BYP_ENTER |-> wif.addr == 23'h000555 && wif.data == 16'h0020)
		else $error("wrong bypass entry write");
	chk_prog_code: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		req_q && st_q == S_CODE && op_q == ffpcd_pkg::OP_PROGRAM |-> wif.data == 16'h00a0)
		else $error("wrong program setup code");
	chk_erase_arg: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		req_q && st_q inside {S_ARG, S_LOAD} && op_q == ffpcd_pkg::OP_BLK_ERASE |-> wif.data == 16'h0030)
		else $error("block erase write not 30");
	chk_chip_arg: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		req_q && st_q == S_ARG && op_q == ffpcd_pkg::OP_CHIP_ERASE |-> wif.data == 16'h0010)
		else $error("chip erase write not 10");
	chk_cfi_single: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		st_q == S_CODE && op_q == ffpcd_pkg::OP_CFI && wif.done |=> st_q == S_IDLE)
		else $error("cfi query took more than one write");
	chk_count_limit: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		cmd_take && cmd_op == ffpcd_pkg::OP_WBUF && CMD_COUNT > 8'h1f |=> CMD_REFUSED && !CMD_ACCEPT)
		else $error("oversize buffer count accepted");
	chk_page_share: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		req_q && st_q == S_LOAD && op_q == ffpcd_pkg::OP_WBUF |-> wif.addr[22:5] == addr_q[22:5])
		else $error("buffer word outside page");
	chk_confirm_addr: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		req_q && st_q == S_CONF && op_q == ffpcd_pkg::OP_WBUF |-> wif.addr == addr_q && wif.data == 16'h0029)
		else $error("confirm write wrong");
	chk_enh_unlock: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		acc_q && op_q == ffpcd_pkg::OP_ENH |-> (st_q == S_CODE) == bypass_q)
		else $error("enhanced unlock choice wrong");

endmodule

`default_nettype wire

/* File: rtl/ffpcd_wr_if.sv */
`timescale 1ns/10ps
`default_nettype none

// carries one bus-write request and the flash write pins
interface ffpcd_wr_if;
	logic                          req;
	logic [ffpcd_pkg::ADDR_W-1:0]  addr;
	logic [ffpcd_pkg::DATA_W-1:0]  data;
	logic                          done;
	logic [ffpcd_pkg::ADDR_W-1:0]  pin_addr;
	logic [ffpcd_pkg::DATA_W-1:0]  pin_dq;
	logic                          pin_dq_oe;
	logic                          pin_ce_n;
	logic                          pin_we_n;

	modport ctrl (output req, output addr, output data, input done,
		input pin_addr, input pin_dq, input pin_dq_oe, input pin_ce_n, input pin_we_n);
	modport wrt (input req, input addr, input data, output done,
		output pin_addr, output pin_dq, output pin_dq_oe, output pin_ce_n, output pin_we_n);
endinterface

`default_nettype wire

/* File: rtl/ffpcd_writer.sv */
// Purpose: one asynchronous flash bus-write cycle per request
// Assumes: request and its address/data stay steady until done
// Notes:   chip enable frames the write, data held through we rising
`timescale 1ns/10ps
`default_nettype none

module ffpcd_writer (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// request side and pins
	ffpcd_wr_if.wrt    wif
);

	typedef enum logic [4:0] {
		W_IDLE  = 5'b00001,
		W_SETUP = 5'b00010,
		W_LOW   = 5'b00100,
		W_HIGH  = 5'b01000,
		W_DONE  = 5'b10000
	} ffpcd_wst_t;

	ffpcd_wst_t                    st_q, st_d;
	logic [3:0]                    cnt_q, cnt_d;
	logic [ffpcd_pkg::ADDR_W-1:0]  a_q;
	logic [ffpcd_pkg::DATA_W-1:0]  dq_q;
	logic                          oe_q, ce_n_q, we_n_q;
	wire                           cnt_zero = (cnt_q == 4'h0);

	// cycle sequencing
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			W_IDLE:  if (wif.req) st_d = W_SETUP;
			W_SETUP: begin
				st_d  = W_LOW;
				cnt_d = 4'(ffpcd_pkg::WP_CYC - 1);
			end
			W_LOW:   if (cnt_zero) begin
				st_d  = W_HIGH;
				cnt_d = 4'(ffpcd_pkg::WPH_CYC - 1);
			end else cnt_d = cnt_q - 4'h1;
			W_HIGH:  if (cnt_zero) st_d = W_DONE;
				else cnt_d = cnt_q - 4'h1;
			W_DONE:  st_d = W_IDLE;
		endcase
	end

	// pin registers; address and data latch when the request is taken
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q   <= W_IDLE;
			cnt_q  <= 4'h0;
			a_q    <= '0;
			dq_q   <= '0;
			oe_q   <= 1'b0;
			ce_n_q <= 1'b1;
			we_n_q <= 1'b1;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			if (st_q == W_IDLE && wif.req) begin
				a_q  <= wif.addr;
				dq_q <= wif.data;
			end
			oe_q   <= (st_d != W_IDLE) && (st_d != W_DONE);
			ce_n_q <= (st_d == W_IDLE) || (st_d == W_DONE);
			we_n_q <= (st_d != W_LOW);
		end
	end

	assign wif.done      = (st_q == W_DONE);
	assign wif.pin_addr  = a_q;
	assign wif.pin_dq    = dq_q;
	assign wif.pin_dq_oe = oe_q;
	assign wif.pin_ce_n  = ce_n_q;
	assign wif.pin_we_n  = we_n_q;

	// write strobe framed by chip enable, data steady while low
	chk_we_framed: assert property (@(posedge clk) disable iff (rst) !we_n_q |-> !ce_n_q && oe_q)
		else $error("write strobe outside chip enable");
	chk_we_width: assert property (@(posedge clk) disable iff (rst) $fell(we_n_q) |=> we_n_q ##1 ce_n_q)
		else $error("write strobe width wrong");
	chk_data_hold: assert property (@(posedge clk) disable iff (rst) !we_n_q |=> $stable(dq_q) && $stable(a_q))
		else $error("data moved around write strobe");

endmodule

`default_nettype wire

/* File: tb/ffpcd_flash_model.sv */
// Purpose: flash partner, records bus writes and drives ready/busy
// Assumes: a write completes when write enable rises with chip enable low
// Notes:   busy alternates short and long so the host must really wait
`timescale 1ns/10ps
`default_nettype none
module ffpcd_flash_model (
	// host pins and status
	input  wire logic        clk,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic [22:0] addr,
	input  wire logic [15:0] dq,
	input  wire logic        oe,
	output logic             rb_n
);
	logic [38:0] wq[$];
	logic [38:0] h1 = '0, h2 = '0;
	logic        byp = 1'b0, we_q = 1'b1, lng = 1'b0, st;
	// extended mode: this host never enters it, so it stays off
	// no reads are made, so bypass leaves array reads alone
	logic        ext = 1'b0;
	int          bcnt = 0;
	assign rb_n = (bcnt == 0);
	// sampled on the clock, so pin updates of this edge are not seen yet
	always @(posedge clk) begin
		st = 1'b0;
		if (we_n && !we_q && !ce_n && oe) begin
			wq.push_back({addr, dq});
			// unlock then 20 enters bypass, not in extended mode
			if ({h2, h1, addr, dq} == {23'h555, 16'haa, 23'h2aa, 16'h55, 23'h555, 16'h20} && !ext) byp = 1'b1;
			if (h1[15:0] == 16'h90 && dq == 16'h00) byp = 1'b0;
			st = h1[15:0] == 16'ha0 || dq == 16'h29 || (h1[15:0] == 16'h80 && dq != 16'h80);
			h2 = h1;
			h1 = {addr, dq};
		end
		bcnt <= st ? (lng ? 40 : 2) : (bcnt > 0 ? bcnt - 1 : 0);
		if (st) lng = !lng;
		we_q = we_n;
	end
endmodule
`default_nettype wire

/* File: tb/ffpcd_top_tb.sv */
// Purpose: self-checking bench for the fast program command sequencer
// Assumes: the partner model records every flash bus write
// Notes:   expected writes come from a queue model of the command table
`timescale 1ns/10ps
`default_nettype none
module ffpcd_top_tb;
	logic        clk = 1'b0, rst = 1'b1, cv = 1'b0, wv = 1'b1, eb = 1'b0;
	logic [3:0]  op = 4'h0;
	logic [22:0] ca = 23'h0, wa = 23'h0, fa;
	logic [15:0] cd = 16'h0, wd = 16'h0, fd;
	logic [7:0]  cn = 8'h0;
	logic        acc, rfs, dn, bsy, byp, wr, oe, ce, we, goe, rb;
	logic [38:0] exq[$], wtq[$];
	int          fails = 0, tests_run = 0, seed = 32'h4db5;
	// free-running clock
	initial forever #50 clk = ~clk;
	ffpcd_top ffpcd_top_i (.REF_CLK(clk), .SYS_RST(rst), .CMD_VALID(cv), .CMD_OP(op), .CMD_ADDR(ca),
		.CMD_DATA(cd), .CMD_COUNT(cn), .CMD_ACCEPT(acc), .CMD_REFUSED(rfs), .CMD_DONE(dn), .BUSY(bsy),
		.BYPASS(byp), .WD_VALID(wv), .WD_ADDR(wa), .WD_DATA(wd), .WD_READY(wr), .FL_ADDR(fa),
		.FL_DQ_O(fd), .FL_DQ_OE(oe), .FL_CE_N(ce), .FL_WE_N(we), .FL_OE_N(goe), .FL_RB_N(rb));
	ffpcd_flash_model ffpcd_flash_model_i (.clk(clk), .ce_n(ce), .we_n(we), .addr(fa), .dq(fd), .oe(oe),
		.rb_n(rb));
	// keep each taken word, then offer a fresh one
	always @(posedge clk) if (wr) begin
		wtq.push_back({wa, wd});
		wa <= 23'($random(seed));
		wd <= 16'($random(seed));
	end
	task automatic chk(input logic [38:0] g, input logic [38:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wx(input logic [22:0] a, input logic [15:0] d);
		exq.push_back({a, d});
	endtask
	// offer one command, then compare every flash write it made
	task automatic cmd(input logic [3:0] o, input logic [7:0] n);
		logic rf;
		int   k;
		int   ew;
		rf = o > 4'h8 || (o inside {[4'h1:4'h5]} && !eb) || (o == 4'h0 && eb) || (o == 4'h6 && n >= 8'd32);
		ew = o == 4'h3 ? int'(n) : o == 4'h6 ? int'(n) + 1 : o == 4'h7 ? 256 : 0;
		@(posedge clk);
		op <= o;
		cn <= n;
		ca <= 23'($random(seed));
		cd <= 16'($random(seed));
		cv <= 1'b1;
		k = 0;
		do begin @(posedge clk); k++; end while (!(acc || rfs) && k < 9);
		cv <= 1'b0;
		chk(39'({acc, rfs, bsy}), 39'({!rf, rf, !rf})); // refusal
		if (!rf) begin
			k = 0;
			while (!dn && k < 3000) begin @(posedge clk); k++; end
			chk(39'({dn, bsy}), 39'h2); // done and idle
			if (o == 4'h0 || o == 4'h8 || (o > 4'h5 && !eb)) begin wx(23'h555, 16'haa); wx(23'h2aa, 16'h55); end
			case (o)
			4'h0: begin wx(23'h555, 16'h20); eb = 1'b1; end
			4'h8: wx(23'h555, 16'hf0);
			4'h1: begin wx(ca, 16'h90); wx(ca, 16'h00); eb = 1'b0; end
			4'h2: begin wx(ca, 16'ha0); wx(ca, cd); end
			4'h3: begin wx(ca, 16'h80); wx(ca, 16'h30); foreach (wtq[i]) wx(wtq[i][38:16], 16'h30); end
			4'h4: begin wx(ca, 16'h80); wx(ca, 16'h10); end
			4'h5: wx(ca, 16'h98);
			4'h6: begin wx(ca, 16'h25); wx(ca, 16'(n));
				foreach (wtq[i]) wx({ca[22:5], wtq[i][20:16]}, wtq[i][15:0]); wx(ca, 16'h29); end
			default: begin wx(ca, 16'h33);
				foreach (wtq[i]) wx({ca[22:8], 8'(i)}, wtq[i][15:0]); wx({ca[22:8], 8'h00}, 16'h29); end
			endcase
			chk(39'(wtq.size()), 39'(ew)); // word count
		end
		repeat (2) @(posedge clk);
		chk(39'(ffpcd_flash_model_i.wq.size()), 39'(exq.size())); // write count
		foreach (exq[i]) chk(ffpcd_flash_model_i.wq[i], exq[i]); // each write
		chk(39'({byp, ffpcd_flash_model_i.byp}), 39'({eb, eb})); // mode flag
		chk(39'({goe, oe, ce, we}), 39'hb); // pins idle, no reads
		exq.delete();
		wtq.delete();
		ffpcd_flash_model_i.wq.delete();
	endtask
	task automatic report_and_stop();
		if (fails == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// command list, refusals mixed in
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cmd(4'h1, 8'h0); // exit outside bypass
		cmd(4'h9, 8'h0);
		cmd(4'h0, 8'h0); // entry
		cmd(4'h8, 8'h0); // abort keeps mode
		cmd(4'h0, 8'h0); // second entry, refused in bypass
		cmd(4'h2, 8'h0); // word program
		cmd(4'h3, 8'h2); // extra blocks
		cmd(4'h4, 8'h0); // chip erase
		cmd(4'h5, 8'h0); // query
		cmd(4'h6, 8'd32); // count too big
		cmd(4'h6, 8'd31); // full page
		cmd(4'h7, 8'h0); // enhanced in bypass, 256 words
		cmd(4'h1, 8'h0); // exit
		cmd(4'h6, 8'h0); // single word
		cmd(4'h7, 8'h0); // full enhanced
		report_and_stop();
	end
	// hang guard, well beyond the expected run
	initial begin
		#5000000;
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
